// ### design/ilts_pkg.sv
// Package for the indicator lamp test sequencer: register map, fields, timing, types
package ilts_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int ILTS_CLK_HZ = 25_000_000;
  localparam int ILTS_TICK_MS = 1;
  localparam int ILTS_TICK_CYCLES = (ILTS_CLK_HZ / 1000) * ILTS_TICK_MS;
  localparam int ILTS_STAGE1_MAX_MS = 60_000;
  localparam int ILTS_STEP_MS = 1_000;
  localparam int ILTS_MIN_PULSE_MS = 250;

  // ---------------------------------------------------------------
  // Lamp layout, in scan order (column by column, top to bottom)
  // ---------------------------------------------------------------
  localparam int ILTS_NUM_LAMPS = 62;
  localparam int ILTS_NUM_USER = 48;
  localparam int ILTS_NUM_PB = 12;
  localparam int ILTS_NUM_SRC = 16;
  localparam int ILTS_TRIP_BIT = 0;
  localparam int ILTS_ALARM_BIT = 1;
  localparam int ILTS_PB_LSB = 2;
  localparam int ILTS_USER_LSB = 14;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ILTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ILTS_HOLD_LO_OFS = 8'h04;
  localparam logic [7:0] ILTS_HOLD_HI_OFS = 8'h08;
  localparam logic [7:0] ILTS_STATUS_OFS = 8'h0C;
  localparam logic [7:0] ILTS_REAL_LO_OFS = 8'h10;
  localparam logic [7:0] ILTS_REAL_HI_OFS = 8'h14;
  localparam logic [7:0] ILTS_EVCNT_OFS = 8'h18;
  localparam int ILTS_CTRL_EN_BIT = 0;
  localparam int ILTS_CTRL_SRC_LSB = 8;
  localparam logic [31:0] ILTS_CTRL_RESET = 32'h0000_0000;
  localparam logic [47:0] ILTS_HOLD_RESET = 48'h0000_0000_0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ALL_ON = 2'b01,
    S_SCAN_ON = 2'b10,
    S_SCAN_OFF = 2'b11
  } ilts_state_t;

  typedef struct packed {
    logic [3:0] src;
    logic en;
  } ilts_ctrl_t;

  typedef struct packed {
    logic trig_level;
    logic [6:0] scan_idx;
    logic [1:0] stage;
    logic active;
  } ilts_status_t;

endpackage

// ### design/ilts_sequencer.sv
// Indicator lamp mapping and three-stage lamp test sequencer with Wishbone registers
// Functional notes
// R1 - Enabled test starts from the selected trigger source input.
// R2 - Test covers all lamps, pushbutton lamps included.
// R3 - First stage lights all 62 lamps together.
// R4 - First stage lasts while trigger held; after one minute the test ends.
// R5 - Releasing the trigger in stage one starts stage two automatically.
// R6 - Stage two: all off, then each lamp alone on for one second.
// R7 - Scan goes column by column, top to bottom, from top-left panel.
// R8 - Stage three follows stage two automatically.
// R9 - Stage three: all on, then each lamp alone off for one second.
// R10 - Trigger aborts stage two or three at any moment.
// R11 - Trigger level times stage one; trigger rising edge aborts later stages.
// R12 - Trigger pulses shorter than 250 ms are ignored.
// R13 - During test, lamps show pattern while real states keep updating.
// R14 - At test end lamps show the real states gathered meanwhile.
// R15 - Panel reset button clears no targets while test runs.
// R16 - Test-active flag is set for the whole test.
// R17 - Test start logs a test-initiated event.
// R18 - Trip and alarm lamps light when their operands are one.
// R19 - 48 user lamps each follow their own operand; 1-24 panel two, 25-48 three.
// R20 - Tracking mode (default): user lamp follows its operand.
// R21 - Latched mode: lamp stays lit until panel, remote or operand reset.
// R22 - While disabled, trigger ignored and test-active never set.
// R23 - Abort or timeout returns to idle, drops flag, restores real states.
module ilts_sequencer
  import ilts_pkg::*;
#(
  parameter int TICK_CYCLES = ILTS_TICK_CYCLES,
  parameter int STAGE1_MAX_MS = ILTS_STAGE1_MAX_MS,
  parameter int STEP_MS = ILTS_STEP_MS,
  parameter int MIN_PULSE_MS = ILTS_MIN_PULSE_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ILTS_NUM_SRC-1:0] trig_sources_i,
  input wire logic trip_operand_i,
  input wire logic alarm_operand_i,
  input wire logic [ILTS_NUM_USER-1:0] user_operand_i,
  input wire logic [ILTS_NUM_PB-1:0] pb_lamp_i,
  input wire logic panel_reset_i,
  input wire logic remote_reset_i,
  input wire logic reset_operand_i,
  output logic [ILTS_NUM_LAMPS-1:0] lamp_o,
  output logic lamp_test_active_flag_o,
  output logic test_event_o,
  output logic target_clear_o
);

  // Elaboration guard: every timing counter below is only 16 bits wide
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("TICK_CYCLES out of range");
  if (STAGE1_MAX_MS < 1 || STAGE1_MAX_MS > 65535) $error("STAGE1_MAX_MS out of range");
  if (STEP_MS < 1 || STEP_MS > 65535) $error("STEP_MS out of range");
  if (MIN_PULSE_MS < 1 || MIN_PULSE_MS > 65535) $error("MIN_PULSE_MS out of range");

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] STAGE1_LAST = 16'(STAGE1_MAX_MS - 1);
  localparam logic [15:0] STEP_LAST = 16'(STEP_MS - 1);
  localparam logic [15:0] PULSE_LAST = 16'(MIN_PULSE_MS - 1);
  localparam logic [6:0] SCAN_LAST = 7'(ILTS_NUM_LAMPS);

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Mask with one lamp bit set, the lamp at scan step idx (step 0 is the blank step)
  function automatic logic [ILTS_NUM_LAMPS-1:0] step_mask(input logic [6:0] idx);
    logic [ILTS_NUM_LAMPS-1:0] m;
    m = '0;
    for (int i = 0; i < ILTS_NUM_LAMPS; i++) begin
      if (idx == 7'(i + 1)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  ilts_ctrl_t ctrl_reg;
  logic [47:0] hold_reg;
  logic [15:0] evcnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic trig_filt_reg;
  logic trig_rise_reg;
  logic [15:0] filt_cnt_reg;
  ilts_state_t state_reg;
  logic [6:0] idx_reg;
  logic [15:0] ms_cnt_reg;
  logic active_reg;
  logic event_reg;
  logic [ILTS_NUM_LAMPS-1:0] real_reg;
  logic [ILTS_NUM_LAMPS-1:0] lamp_reg;
  logic target_clear_reg;
  ilts_status_t status;
  logic wb_req;
  logic trig_raw;
  logic latch_clear;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_merged;
  logic [31:0] hold_hi_merged;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign status = '{trig_level: trig_filt_reg, scan_idx: idx_reg,
                    stage: state_reg, active: active_reg};
  assign ctrl_word = {20'h0_0000, ctrl_reg.src, 7'h00, ctrl_reg.en};
  assign ctrl_merged = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);
  assign hold_hi_merged = merge_bytes({16'h0000, hold_reg[47:32]}, wb_dat_i, wb_sel_i);

  // ---------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ilts_ctrl_t'(5'(ILTS_CTRL_RESET));
      hold_reg <= ILTS_HOLD_RESET;
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        ILTS_CTRL_OFS: begin
          ctrl_reg.en <= ctrl_merged[ILTS_CTRL_EN_BIT];
          ctrl_reg.src <= ctrl_merged[ILTS_CTRL_SRC_LSB +: 4];
        end
        ILTS_HOLD_LO_OFS: hold_reg[31:0] <= merge_bytes(hold_reg[31:0], wb_dat_i, wb_sel_i);
        ILTS_HOLD_HI_OFS: hold_reg[47:32] <= hold_hi_merged[15:0];
        default: begin
        end
      endcase
    end
  end

  // Unmapped addresses read as zero; every writable register reads back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      case (wb_adr_i)
        ILTS_CTRL_OFS: rdata_reg <= {20'h0_0000, ctrl_reg.src, 7'h00, ctrl_reg.en};
        ILTS_HOLD_LO_OFS: rdata_reg <= hold_reg[31:0];
        ILTS_HOLD_HI_OFS: rdata_reg <= {16'h0000, hold_reg[47:32]};
        ILTS_STATUS_OFS: rdata_reg <= {21'h00_0000, status};
        ILTS_REAL_LO_OFS: rdata_reg <= real_reg[31:0];
        ILTS_REAL_HI_OFS: rdata_reg <= {2'h0, real_reg[61:32]};
        ILTS_EVCNT_OFS: rdata_reg <= {16'h0000, evcnt_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Millisecond time base
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Trigger qualification
  // ---------------------------------------------------------------
  // Disabled function forces the raw trigger low, so nothing can start
  assign trig_raw = ctrl_reg.en && trig_sources_i[ctrl_reg.src]; // [R1] [R22]

  // Level only flips after the raw input held its new value for the full
  // pulse time; the filter costs that much latency on both edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_filt_reg <= 1'b0;
      trig_rise_reg <= 1'b0;
      filt_cnt_reg <= 16'h0000;
    end else begin
      trig_rise_reg <= 1'b0;
      if (trig_raw == trig_filt_reg) begin
        filt_cnt_reg <= 16'h0000;
      end else if (tick_reg) begin
        if (filt_cnt_reg == PULSE_LAST) begin // [R12]
          filt_cnt_reg <= 16'h0000;
          trig_filt_reg <= trig_raw;
          trig_rise_reg <= trig_raw; // [R11]
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Test sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      idx_reg <= 7'h00;
      ms_cnt_reg <= 16'h0000;
      active_reg <= 1'b0;
      event_reg <= 1'b0;
      evcnt_reg <= 16'h0000;
    end else begin
      event_reg <= 1'b0;
      if (!ctrl_reg.en) begin
        state_reg <= S_IDLE; // [R22]
        active_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            idx_reg <= 7'h00;
            ms_cnt_reg <= 16'h0000;
            if (trig_rise_reg) begin
              state_reg <= S_ALL_ON; // [R1]
              active_reg <= 1'b1; // [R16]
              event_reg <= 1'b1; // [R17]
              evcnt_reg <= evcnt_reg + 16'h0001;
            end
          end
          S_ALL_ON: begin
            if (!trig_filt_reg) begin
              state_reg <= S_SCAN_ON; // [R5]
              ms_cnt_reg <= 16'h0000;
            end else if (tick_reg) begin
              if (ms_cnt_reg == STAGE1_LAST) begin
                state_reg <= S_IDLE; // [R4] [R23]
                active_reg <= 1'b0;
              end else begin
                ms_cnt_reg <= ms_cnt_reg + 16'h0001;
              end
            end
          end
          S_SCAN_ON, S_SCAN_OFF: begin
            if (trig_rise_reg) begin
              state_reg <= S_IDLE; // [R10] [R23]
              active_reg <= 1'b0;
            end else if (tick_reg) begin
              if (ms_cnt_reg != STEP_LAST) begin
                ms_cnt_reg <= ms_cnt_reg + 16'h0001; // [R6] [R9]
              end else begin
                ms_cnt_reg <= 16'h0000;
                if (idx_reg != SCAN_LAST) begin
                  idx_reg <= idx_reg + 7'h01; // [R7]
                end else if (state_reg == S_SCAN_ON) begin
                  state_reg <= S_SCAN_OFF; // [R8]
                  idx_reg <= 7'h00;
                end else begin
                  state_reg <= S_IDLE; // [R14]
                  active_reg <= 1'b0;
                end
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            active_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Real indicator states, kept up to date during the test
  // ---------------------------------------------------------------
  // The panel button is held off while testing so targets survive the test
  assign latch_clear = (panel_reset_i && !active_reg) || remote_reset_i
                       || reset_operand_i; // [R15] [R21]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      real_reg <= '0;
    end else begin
      real_reg[ILTS_TRIP_BIT] <= trip_operand_i; // [R18] [R13]
      real_reg[ILTS_ALARM_BIT] <= alarm_operand_i; // [R18]
      real_reg[ILTS_PB_LSB +: ILTS_NUM_PB] <= pb_lamp_i;
      for (int i = 0; i < ILTS_NUM_USER; i++) begin
        if (!hold_reg[i]) begin
          real_reg[ILTS_USER_LSB + i] <= user_operand_i[i]; // [R19] [R20]
        end else if (user_operand_i[i]) begin
          real_reg[ILTS_USER_LSB + i] <= 1'b1; // [R21]
        end else if (latch_clear) begin
          real_reg[ILTS_USER_LSB + i] <= 1'b0; // [R21]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Lamp drive and flag outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamp_reg <= '0;
      target_clear_reg <= 1'b0;
    end else begin
      target_clear_reg <= panel_reset_i && !active_reg; // [R15]
      case (state_reg)
        S_ALL_ON: lamp_reg <= '1; // [R2] [R3]
        S_SCAN_ON: lamp_reg <= step_mask(idx_reg); // [R6] [R13]
        S_SCAN_OFF: lamp_reg <= ~step_mask(idx_reg); // [R9]
        default: lamp_reg <= real_reg; // [R14] [R23]
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign lamp_o = lamp_reg;
  assign lamp_test_active_flag_o = active_reg;
  assign test_event_o = event_reg;
  assign target_clear_o = target_clear_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_disabled_idle: assert property (!ctrl_reg.en |=> state_reg == S_IDLE && !active_reg) // [R22]
    else $error("test running while disabled");
  a_start_event: assert property ($rose(active_reg) |-> event_reg && state_reg == S_ALL_ON) // [R17]
    else $error("test start without event");
  a_flag_tracks: assert property (active_reg == (state_reg != S_IDLE)) // [R16]
    else $error("active flag disagrees with state");
  a_stage1_all: assert property ($past(state_reg) == S_ALL_ON |-> &lamp_reg) // [R3]
    else $error("stage one lamps not all on");
  a_stage1_release: assert property (state_reg == S_ALL_ON && !trig_filt_reg
                                     |=> state_reg == S_SCAN_ON) // [R5]
    else $error("release did not start stage two");
  a_stage1_timeout: assert property (state_reg == S_ALL_ON && trig_filt_reg && tick_reg
                                     && ms_cnt_reg == STAGE1_LAST |=> state_reg == S_IDLE) // [R4]
    else $error("stage one did not time out");
  a_scan_abort: assert property ((state_reg == S_SCAN_ON || state_reg == S_SCAN_OFF)
                                 && trig_rise_reg |=> state_reg == S_IDLE) // [R10]
    else $error("abort ignored");
  a_single_on: assert property ($past(state_reg) == S_SCAN_ON && $past(idx_reg) != 7'h00
                                |-> $onehot(lamp_reg)) // [R6]
    else $error("stage two not single lamp");
  a_single_off: assert property ($past(state_reg) == S_SCAN_OFF && $past(idx_reg) != 7'h00
                                 |-> $onehot(~lamp_reg)) // [R9]
    else $error("stage three not single dark lamp");
  a_reset_blocked: assert property (panel_reset_i && active_reg |=> !target_clear_reg) // [R15]
    else $error("targets cleared during test");
  a_real_restore: assert property ($past(state_reg) == S_IDLE
                                   |-> lamp_reg == $past(real_reg)) // [R14]
    else $error("idle lamps differ from real state");

  c_stage1: cover property (state_reg == S_IDLE ##1 state_reg == S_ALL_ON);
  c_stage3: cover property (state_reg == S_SCAN_ON ##1 state_reg == S_SCAN_OFF);
  c_complete: cover property (state_reg == S_SCAN_OFF ##1 state_reg == S_IDLE);
  c_abort: cover property (state_reg == S_SCAN_ON && trig_rise_reg);

endmodule

// ### testbench/ilts_panel_model.sv
// Front panel lamp model: lit count and position of the first lit and first dark lamp
module ilts_panel_model
  import ilts_pkg::*;
(
  input wire logic [ILTS_NUM_LAMPS-1:0] lamp_i,
  output logic [6:0] lit_cnt_o,
  output logic [6:0] on_idx_o,
  output logic [6:0] off_idx_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Scanned from the top so the lowest index wins
  always_comb begin
    lit_cnt_o = 7'h00;
    on_idx_o = 7'h7F;
    off_idx_o = 7'h7F;
    for (int i = ILTS_NUM_LAMPS - 1; i >= 0; i--) begin
      lit_cnt_o = lit_cnt_o + 7'(lamp_i[i]);
      if (lamp_i[i]) begin
        on_idx_o = 7'(i);
      end else begin
        off_idx_o = 7'(i);
      end
    end
  end
endmodule

// ### testbench/indicator_lamp_test_sequencer_tb.sv
// Self-checking bench for the indicator lamp test sequencer
module indicator_lamp_test_sequencer_tb
  import ilts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Shortened timing, every expectation derives from these
  // ---------------------------------------------------------------
  localparam int TK = 4;
  localparam int S1 = 20;
  localparam int ST = 3;
  localparam int MP = 2;
  localparam int STEP = ST * TK;

  logic clk, rst, cyc, stb, we, ack, trip, alarm, prst, rrst, oprst, flag, evt, tclr;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd, rnd;
  logic [3:0] sel, src;
  logic [15:0] trig;
  logic [47:0] usr;
  logic [11:0] pb;
  logic [61:0] lamp, prev;
  logic [6:0] lit_cnt, on_idx, off_idx;
  int miscompares, n_checks, cyc_cnt, waited;

  ilts_sequencer #(.TICK_CYCLES(TK), .STAGE1_MAX_MS(S1), .STEP_MS(ST), .MIN_PULSE_MS(MP)) dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trig_sources_i(trig), .trip_operand_i(trip), .alarm_operand_i(alarm),
    .user_operand_i(usr), .pb_lamp_i(pb), .panel_reset_i(prst), .remote_reset_i(rrst),
    .reset_operand_i(oprst), .lamp_o(lamp), .lamp_test_active_flag_o(flag),
    .test_event_o(evt), .target_clear_o(tclr));

  ilts_panel_model panel (.lamp_i(lamp), .lit_cnt_o(lit_cnt), .on_idx_o(on_idx),
    .off_idx_o(off_idx));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [61:0] real_exp();
    return {usr, pb, alarm, trip};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Classic single cycle, released only after ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_flag(input logic v, input int lim);
    waited = 0;
    while (flag !== v && waited < lim) begin
      @(posedge clk);
      waited++;
    end
    chk(flag, v);
  endtask

  task automatic new_operands();
    rnd = lfsr(rnd);
    trip <= rnd[0];
    alarm <= rnd[1];
    pb <= rnd[13:2];
    usr <= {rnd[31:16], lfsr(rnd)};
  endtask

  // Stage two (dark=0) or three (dark=1): step 0, then one lamp per step
  task automatic scan(input logic dark);
    int n;
    for (int k = -1; k < ILTS_NUM_LAMPS; k++) begin
      prev = lamp;
      n = 0;
      while (lamp === prev && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (k >= 1) chk(n, STEP);
      if (k < 0) chk(lamp, dark ? {62{1'b1}} : 62'h0);
      else chk({lit_cnt, dark ? off_idx : on_idx}, {dark ? 7'h3D : 7'h01, 7'(k)});
    end
  endtask

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt > 12000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, cyc, stb, we, trip, alarm, prst, rrst, oprst} = 9'h1FF & 9'h100;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    trig = 16'h0;
    usr = 48'h0;
    pb = 12'h000;
    rnd = 32'h11;
    miscompares = 0;
    n_checks = 0;
    cyc_cnt = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, ILTS_CTRL_OFS, 32'h0);
    chk(rd, ILTS_CTRL_RESET);
    wb(1'b0, ILTS_HOLD_LO_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    trig <= 16'hFFFF;
    repeat (100) @(posedge clk);
    chk(flag, 1'b0);
    trig <= 16'h0;
    for (int i = 0; i < 8; i++) begin
      new_operands();
      repeat (3) @(posedge clk);
      chk(lamp, real_exp());
    end
    wb(1'b1, ILTS_HOLD_LO_OFS, 32'h1);
    usr <= 48'h1;
    repeat (3) @(posedge clk);
    usr <= 48'h0;
    repeat (3) @(posedge clk);
    chk(lamp[14], 1'b1);
    rrst <= 1'b1;
    repeat (3) @(posedge clk);
    rrst <= 1'b0;
    chk(lamp[14], 1'b0);
    usr <= 48'h1;
    repeat (3) @(posedge clk);
    usr <= 48'h0;
    repeat (3) @(posedge clk);
    chk(lamp[14], 1'b1);
    oprst <= 1'b1;
    repeat (3) @(posedge clk);
    oprst <= 1'b0;
    chk(lamp[14], 1'b0);
    prst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(tclr, 1'b1);
    prst <= 1'b0;
    wb(1'b1, ILTS_HOLD_LO_OFS, 32'h0);
    rnd = lfsr(rnd);
    src = rnd[3:0];
    wb(1'b1, ILTS_CTRL_OFS, {20'h0, src, 7'h00, 1'b1});
    trig <= ~(16'h1 << src);
    repeat (60) @(posedge clk);
    chk(flag, 1'b0);
    trig <= 16'h1 << src;
    repeat (3) @(posedge clk);
    trig <= 16'h0;
    repeat (40) @(posedge clk);
    chk(flag, 1'b0);
    // Full run: hold, release, both scans
    trig[src] <= 1'b1;
    wait_flag(1'b1, MP * TK + 2 * TK + 4);
    chk(evt, 1'b1);
    @(posedge clk);
    chk(lamp, {62{1'b1}});
    new_operands();
    prst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(tclr, 1'b0);
    prst <= 1'b0;
    trig[src] <= 1'b0;
    scan(1'b0);
    scan(1'b1);
    wait_flag(1'b0, 2 * STEP);
    repeat (2) @(posedge clk);
    chk(lamp, real_exp());
    wb(1'b0, ILTS_EVCNT_OFS, 32'h0);
    chk(rd[15:0], 16'h0001);
    // Stage one held past its limit
    trig[src] <= 1'b1;
    wait_flag(1'b1, MP * TK + 2 * TK + 4);
    wait_flag(1'b0, S1 * TK + 2 * TK);
    chk(waited >= (S1 - 1) * TK, 1'b1);
    repeat (2) @(posedge clk);
    chk(lamp, real_exp());
    trig[src] <= 1'b0;
    repeat (40) @(posedge clk);
    chk(flag, 1'b0);
    // Abort in mid-scan by a new rising edge
    trig[src] <= 1'b1;
    wait_flag(1'b1, MP * TK + 2 * TK + 4);
    trig[src] <= 1'b0;
    repeat (MP * TK + 5 * STEP) @(posedge clk);
    new_operands();
    trig[src] <= 1'b1;
    wait_flag(1'b0, MP * TK + 2 * TK + 4);
    repeat (2) @(posedge clk);
    chk(lamp, real_exp());
    trig[src] <= 1'b0;
    repeat (40) @(posedge clk);
    chk(flag, 1'b0);
    // Disabling in mid-test ends it at once
    trig[src] <= 1'b1;
    wait_flag(1'b1, MP * TK + 2 * TK + 4);
    wb(1'b1, ILTS_CTRL_OFS, 32'h0);
    wait_flag(1'b0, 3);
    repeat (2) @(posedge clk);
    chk(lamp, real_exp());
    report_and_stop();
  end
endmodule
